// file: logic/cache_statistics_unit.sv
`timescale 1ns/1ps
// Function
// - Read latency mode picks start valid/handshake and end first/last data.
// - Write latency modes 0-3 end on data, 4-7 on write response.
// - Read latency mode resets to 0, write latency mode to 4.
// - Enable at 0 stops all collection, at 1 collects.
// - Enable reads back its value and resets to 1.
// - Any write to the clear location wipes all statistics; write-only.
// - Event record words: count, extremes/status, sum, sum of squares.
// - Event count increments once per monitored event.
// - Queue word 0 counts cycles the queue was empty.
// - Queue word 1 counts cycles with a push or pop.
// - Queue word 2 holds the peak depth in the max field and overflow in bit 0.
// - Queue word 3 adds current depth in each cycle with a push or pop.
// - Address bit 2 selects low or high half of each 64-bit word.
// - Extremes word: min 63:48, max 47:32, zeros in 31:2.
// - Max field tracks largest value, stopping at 0xFFFF.
// - Bit 1 flags concurrent measurement limit reached.
// - Bit 0 flags any saturated measurement in the record.
// - Queue records for write address, write data, read address.
// - Event record for read search depth before release.
// - Separate records for search stalls and conflict stalls.
// - Read and write latency records use their configured window.
// - One clock; logic operational two cycles after reset release.
module cache_statistics_unit
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Register port
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [cache_stats_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [cache_stats_pkg::DATA_W-1:0] reg_wdata_i,
	output logic [cache_stats_pkg::DATA_W-1:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// Back-end queue monitors
	input wire cache_stats_pkg::queue_mon_t wr_addr_q_i,
	input wire cache_stats_pkg::queue_mon_t wr_data_q_i,
	input wire cache_stats_pkg::queue_mon_t rd_addr_q_i,
	// Back-end event measurements
	input wire cache_stats_pkg::meas_t search_depth_i,
	input wire cache_stats_pkg::meas_t search_stall_i,
	input wire cache_stats_pkg::meas_t conflict_stall_i,
	// External memory channel monitors
	input wire cache_stats_pkg::chan_mon_t mem_rd_i,
	input wire cache_stats_pkg::chan_mon_t mem_wr_i
);

	localparam int NQ = cache_stats_pkg::NUM_QUEUES;
	localparam int NE = cache_stats_pkg::NUM_EVENTS;
	localparam int MW = cache_stats_pkg::MEAS_W;
	localparam int WW = cache_stats_pkg::WORD_W;

	logic [1:0] rdy_q;
	logic ready;
	logic en_q;
	logic clr_q;
	logic col_en;
	logic [cache_stats_pkg::MODE_W-1:0] rd_mode_q;
	logic [cache_stats_pkg::MODE_W-1:0] wr_mode_q;
	logic [3:0] rec;
	logic [1:0] wsel;
	logic ctl_unit;

	cache_stats_pkg::queue_mon_t qmon [NQ];
	cache_stats_pkg::meas_t ev_meas [NE];
	logic ev_full [NE];

	logic [WW-1:0] q_idle_q [NQ];
	logic [WW-1:0] q_upd_q [NQ];
	logic [WW-1:0] q_sum_q [NQ];
	logic [MW-1:0] q_max_q [NQ];
	logic q_ovf_q [NQ];

	logic [WW-1:0] ev_cnt_q [NE];
	logic [WW-1:0] ev_sum_q [NE];
	logic [WW-1:0] ev_sq_q [NE];
	logic [MW-1:0] ev_min_q [NE];
	logic [MW-1:0] ev_max_q [NE];
	logic ev_minv_q [NE];
	logic ev_full_q [NE];
	logic ev_ovf_q [NE];

	// Saturating 64-bit add; the top bit reports that the sum was clipped
	function automatic logic [WW:0] sat_add(input logic [WW-1:0] a,
		input logic [WW-1:0] b);
		logic [WW:0] s;
		s = {1'b0, a} + {1'b0, b};
		if (s[WW])
		begin
			s[WW-1:0] = '1;
		end
		return s;
	endfunction

	assign ready = rdy_q[1];
	assign col_en = en_q & ready;
	assign rec = reg_addr_i[cache_stats_pkg::REC_HI:cache_stats_pkg::REC_LO];
	assign wsel = reg_addr_i[cache_stats_pkg::WSEL_HI:cache_stats_pkg::WSEL_LO];
	assign ctl_unit = reg_addr_i[cache_stats_pkg::UNIT_BIT];

	assign qmon[0] = wr_addr_q_i;
	assign qmon[1] = wr_data_q_i;
	assign qmon[2] = rd_addr_q_i;
	assign ev_meas[0] = search_depth_i;
	assign ev_meas[1] = search_stall_i;
	assign ev_meas[2] = conflict_stall_i;
	assign ev_full[0] = 1'b0;
	assign ev_full[1] = 1'b0;
	assign ev_full[2] = 1'b0;

	// Accesses are ignored until the third edge after release
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			rdy_q <= 2'h0;
		else
			rdy_q <= {rdy_q[0], 1'b1};
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			en_q <= cache_stats_pkg::ENABLE_RST;
			rd_mode_q <= cache_stats_pkg::RD_MODE_RST;
			wr_mode_q <= cache_stats_pkg::WR_MODE_RST;
		end
		else if (reg_wr_i && ready && !reg_addr_i[cache_stats_pkg::HALF_BIT])
		begin
			if (ctl_unit && rec == cache_stats_pkg::REC_ENABLE)
				en_q <= reg_wdata_i[0];
			if (!ctl_unit && rec == cache_stats_pkg::REC_RD_LAT_MODE)
				rd_mode_q <= reg_wdata_i[cache_stats_pkg::MODE_W-1:0];
			if (!ctl_unit && rec == cache_stats_pkg::REC_WR_LAT_MODE)
				wr_mode_q <= reg_wdata_i[cache_stats_pkg::MODE_W-1:0];
		end
	end

	// Clear is registered so a wide fan-out does not sit on the bus path
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			clr_q <= 1'b0;
		else
			clr_q <= reg_wr_i && ready && ctl_unit &&
				rec == cache_stats_pkg::REC_CLEAR;
	end

	// Latency trackers: one transaction measured at a time
	generate
		for (genvar l = 0; l < 2; l++)
		begin : g_lat
			cache_stats_pkg::chan_mon_t ch;
			logic use_hs;
			logic hs;
			logic fin;
			logic busy_q;
			logic addr_q;
			logic [MW-1:0] cnt_q;
			if (l == 0)
			begin : g_rd
				assign ch = mem_rd_i;
				assign use_hs = rd_mode_q[0];
				assign fin = ch.data_valid && ch.data_ready &&
					(ch.data_last || !rd_mode_q[1]);
			end
			else
			begin : g_wr
				assign ch = mem_wr_i;
				assign use_hs = wr_mode_q[0];
				assign fin = (wr_mode_q >= cache_stats_pkg::WR_MODE_RESP_V) ?
					(ch.resp_valid && ch.resp_ready) :
					(ch.data_valid && ch.data_ready &&
					(ch.data_last || !wr_mode_q[1]));
			end
			assign hs = ch.addr_valid && ch.addr_ready;

			always_ff @(posedge ref_clk_i or negedge rst_n_i)
			begin
				if (!rst_n_i)
				begin
					busy_q <= 1'b0;
					addr_q <= 1'b0;
					cnt_q <= '0;
				end
				else if (!busy_q)
				begin
					if (col_en && (use_hs ? hs : ch.addr_valid))
					begin
						busy_q <= 1'b1;
						addr_q <= hs;
						cnt_q <= MW'(1);
					end
				end
				else
				begin
					if (hs)
						addr_q <= 1'b1;
					if (addr_q && fin)
						busy_q <= 1'b0;
					if (cnt_q != cache_stats_pkg::MEAS_MAX)
						cnt_q <= cnt_q + MW'(1);
				end
			end

			assign ev_meas[NQ + l].valid = busy_q && addr_q && fin;
			assign ev_meas[NQ + l].value = cnt_q;
			assign ev_meas[NQ + l].sat = (cnt_q == cache_stats_pkg::MEAS_MAX);
			// A second address while one is in flight goes unmeasured
			assign ev_full[NQ + l] = col_en && busy_q && addr_q && hs;
		end
	endgenerate

	// Queue records
	generate
		for (genvar g = 0; g < NQ; g++)
		begin : g_queue
			logic upd;
			logic [WW:0] idle_s;
			logic [WW:0] upd_s;
			logic [WW:0] sum_s;
			logic [WW-1:0] b_idle;
			logic [WW-1:0] b_upd;
			logic [WW-1:0] b_sum;
			logic [MW-1:0] b_max;
			assign upd = col_en && (qmon[g].push || qmon[g].pop);
			assign b_idle = clr_q ? '0 : q_idle_q[g];
			assign b_upd = clr_q ? '0 : q_upd_q[g];
			assign b_sum = clr_q ? '0 : q_sum_q[g];
			assign b_max = clr_q ? '0 : q_max_q[g];
			assign idle_s = sat_add(b_idle, WW'(1));
			assign upd_s = sat_add(b_upd, WW'(1));
			assign sum_s = sat_add(b_sum, WW'(qmon[g].depth));

			always_ff @(posedge ref_clk_i or negedge rst_n_i)
			begin
				if (!rst_n_i)
				begin
					q_idle_q[g] <= '0;
					q_upd_q[g] <= '0;
					q_sum_q[g] <= '0;
					q_max_q[g] <= '0;
					q_ovf_q[g] <= 1'b0;
				end
				else
				begin
					q_idle_q[g] <= (col_en && qmon[g].empty) ?
						idle_s[WW-1:0] : b_idle;
					q_upd_q[g] <= upd ? upd_s[WW-1:0] : b_upd;
					q_sum_q[g] <= upd ? sum_s[WW-1:0] : b_sum;
					q_max_q[g] <= (upd && qmon[g].depth > b_max) ?
						qmon[g].depth : b_max;
					q_ovf_q[g] <= (q_ovf_q[g] && !clr_q) ||
						(col_en && qmon[g].empty && idle_s[WW]) ||
						(upd && (upd_s[WW] || sum_s[WW]));
				end
			end
		end
	endgenerate

	// Event records
	generate
		for (genvar e = 0; e < NE; e++)
		begin : g_event
			logic hit;
			logic [MW-1:0] v;
			logic [WW:0] cnt_s;
			logic [WW:0] sum_s;
			logic [WW:0] sq_s;
			logic [WW-1:0] b_cnt;
			logic [WW-1:0] b_sum;
			logic [WW-1:0] b_sq;
			logic [MW-1:0] b_max;
			assign hit = col_en && ev_meas[e].valid;
			assign v = ev_meas[e].value;
			assign b_cnt = clr_q ? '0 : ev_cnt_q[e];
			assign b_sum = clr_q ? '0 : ev_sum_q[e];
			assign b_sq = clr_q ? '0 : ev_sq_q[e];
			assign b_max = clr_q ? '0 : ev_max_q[e];
			assign cnt_s = sat_add(b_cnt, WW'(1));
			assign sum_s = sat_add(b_sum, WW'(v));
			assign sq_s = sat_add(b_sq, WW'(v) * WW'(v));

			always_ff @(posedge ref_clk_i or negedge rst_n_i)
			begin
				if (!rst_n_i)
				begin
					ev_cnt_q[e] <= '0;
					ev_sum_q[e] <= '0;
					ev_sq_q[e] <= '0;
					ev_min_q[e] <= '0;
					ev_max_q[e] <= '0;
					ev_minv_q[e] <= 1'b0;
				end
				else if (hit)
				begin
					ev_cnt_q[e] <= cnt_s[WW-1:0];
					ev_sum_q[e] <= sum_s[WW-1:0];
					ev_sq_q[e] <= sq_s[WW-1:0];
					ev_max_q[e] <= (v > b_max) ? v : b_max;
					ev_min_q[e] <= (clr_q || !ev_minv_q[e] ||
						v < ev_min_q[e]) ? v : ev_min_q[e];
					ev_minv_q[e] <= 1'b1;
				end
				else if (clr_q)
				begin
					ev_cnt_q[e] <= '0;
					ev_sum_q[e] <= '0;
					ev_sq_q[e] <= '0;
					ev_min_q[e] <= '0;
					ev_max_q[e] <= '0;
					ev_minv_q[e] <= 1'b0;
				end
			end

			// Set wins over a clear in the same cycle
			always_ff @(posedge ref_clk_i or negedge rst_n_i)
			begin
				if (!rst_n_i)
				begin
					ev_full_q[e] <= 1'b0;
					ev_ovf_q[e] <= 1'b0;
				end
				else
				begin
					ev_full_q[e] <= (ev_full_q[e] && !clr_q) ||
						ev_full[e];
					ev_ovf_q[e] <= (ev_ovf_q[e] && !clr_q) || (hit &&
						(ev_meas[e].sat || cnt_s[WW] || sum_s[WW] ||
						sq_s[WW]));
				end
			end
		end
	endgenerate

	// Read path: pick a 64-bit word, then the half
	logic [WW-1:0] rd_word;
	always_comb
	begin
		int qi;
		int ei;
		qi = 0;
		ei = 0;
		rd_word = '0;
		if (!ctl_unit && rec < 4'(NQ))
		begin
			qi = int'(rec);
			case (wsel)
				cache_stats_pkg::WORD_0: rd_word = q_idle_q[qi];
				cache_stats_pkg::WORD_1: rd_word = q_upd_q[qi];
				cache_stats_pkg::WORD_2: rd_word = {{MW{1'b0}}, q_max_q[qi],
					30'h0, 1'b0, q_ovf_q[qi]};
				cache_stats_pkg::WORD_3: rd_word = q_sum_q[qi];
				default: rd_word = '0;
			endcase
		end
		else if (!ctl_unit && rec < 4'(NQ + NE))
		begin
			ei = int'(rec) - NQ;
			case (wsel)
				cache_stats_pkg::WORD_0: rd_word = ev_cnt_q[ei];
				cache_stats_pkg::WORD_1: rd_word = {ev_min_q[ei], ev_max_q[ei],
					30'h0, ev_full_q[ei], ev_ovf_q[ei]};
				cache_stats_pkg::WORD_2: rd_word = ev_sum_q[ei];
				cache_stats_pkg::WORD_3: rd_word = ev_sq_q[ei];
				default: rd_word = '0;
			endcase
		end
		else if (!ctl_unit && rec == cache_stats_pkg::REC_RD_LAT_MODE)
			rd_word = WW'(rd_mode_q);
		else if (!ctl_unit && rec == cache_stats_pkg::REC_WR_LAT_MODE)
			rd_word = WW'(wr_mode_q);
		else if (ctl_unit && rec == cache_stats_pkg::REC_ENABLE)
			rd_word = WW'(en_q);
		else
			rd_word = '0;
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			reg_rdata_o <= '0;
			reg_rvalid_o <= 1'b0;
		end
		else
		begin
			reg_rvalid_o <= reg_rd_i && ready;
			if (reg_rd_i && ready)
				reg_rdata_o <= reg_addr_i[cache_stats_pkg::HALF_BIT] ?
					rd_word[WW-1:cache_stats_pkg::DATA_W] :
					rd_word[cache_stats_pkg::DATA_W-1:0];
		end
	end

	localparam int EV_RD_LAT_IDX = cache_stats_pkg::EV_RD_LAT;

	a_mode_reset_vals: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) !rdy_q[0] |-> rd_mode_q == 3'h0 &&
		wr_mode_q == 3'h4)
		else $error("latency modes not at reset values");

	a_enable_default: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) !rdy_q[1] |-> en_q)
		else $error("enable not set after reset");

	a_count_step: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) col_en && ev_meas[0].valid && !clr_q &&
		ev_cnt_q[0] != '1 |=> ev_cnt_q[0] == $past(ev_cnt_q[0]) + 64'h1)
		else $error("event count did not step by one");

	a_hold_disabled: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) !col_en && !clr_q |=>
		$stable(ev_cnt_q[0]) && $stable(q_sum_q[0]) && $stable(q_idle_q[1]))
		else $error("statistics changed while disabled");

	a_clear_all: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) reg_wr_i && ready && ctl_unit &&
		rec == cache_stats_pkg::REC_CLEAR ##1 !ev_meas[4].valid &&
		!ev_full[3] && !qmon[2].push && !qmon[2].pop |=>
		ev_cnt_q[4] == 64'h0 && q_max_q[2] == 16'h0 && !ev_full_q[3])
		else $error("clear left statistics behind");

	a_half_select: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) reg_rd_i && ready && !ctl_unit &&
		rec == 4'h3 && wsel == 2'h0 && reg_addr_i[2] && !col_en && !clr_q
		|=> reg_rvalid_o && reg_rdata_o == ev_cnt_q[0][63:32])
		else $error("high half read wrong");

	a_idle_count: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) col_en && qmon[0].empty && !clr_q &&
		q_idle_q[0] != '1 |=> q_idle_q[0] == $past(q_idle_q[0]) + 64'h1)
		else $error("empty cycles not counted");

	a_hs_start: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) !g_lat[0].busy_q && rd_mode_q == 3'h1 &&
		mem_rd_i.addr_valid && !mem_rd_i.addr_ready |=> !g_lat[0].busy_q)
		else $error("read latency started before handshake");

	a_full_flag: assert property (@(posedge ref_clk_i)
		disable iff (!rst_n_i) ev_full[EV_RD_LAT_IDX] |=> ev_full_q[3])
		else $error("full flag not raised");

endmodule

// file: logic/cache_stats_pkg.sv
package cache_stats_pkg;

	// Register port geometry
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam int WORD_W = 64;
	localparam int MEAS_W = 16;
	localparam int MODE_W = 3;

	// Address fields: unit select, record index, word index, half select
	localparam int UNIT_BIT = 9;
	localparam int REC_HI = 8;
	localparam int REC_LO = 5;
	localparam int WSEL_HI = 4;
	localparam int WSEL_LO = 3;
	localparam int HALF_BIT = 2;

	// Back-end record indices
	localparam logic [3:0] REC_WR_ADDR_Q = 4'h0;
	localparam logic [3:0] REC_WR_DATA_Q = 4'h1;
	localparam logic [3:0] REC_RD_ADDR_Q = 4'h2;
	localparam logic [3:0] REC_SEARCH_DEPTH = 4'h3;
	localparam logic [3:0] REC_SEARCH_STALL = 4'h4;
	localparam logic [3:0] REC_CONFLICT_STALL = 4'h5;
	localparam logic [3:0] REC_RD_LATENCY = 4'h6;
	localparam logic [3:0] REC_WR_LATENCY = 4'h7;
	localparam logic [3:0] REC_RD_LAT_MODE = 4'h8;
	localparam logic [3:0] REC_WR_LAT_MODE = 4'h9;
	// Control unit record indices
	localparam logic [3:0] REC_CLEAR = 4'h0;
	localparam logic [3:0] REC_ENABLE = 4'h1;

	localparam int NUM_QUEUES = 3;
	localparam int NUM_EVENTS = 5;
	localparam int EV_RD_LAT = 3;
	localparam int EV_WR_LAT = 4;

	// Word index inside a record
	localparam logic [1:0] WORD_0 = 2'h0;
	localparam logic [1:0] WORD_1 = 2'h1;
	localparam logic [1:0] WORD_2 = 2'h2;
	localparam logic [1:0] WORD_3 = 2'h3;

	// Reset values and the measurement limit
	localparam logic [MODE_W-1:0] RD_MODE_RST = 3'h0;
	localparam logic [MODE_W-1:0] WR_MODE_RST = 3'h4;
	localparam logic ENABLE_RST = 1'b1;
	localparam logic [MEAS_W-1:0] MEAS_MAX = 16'hFFFF;

	// Write latency windows that end on the write response
	localparam logic [MODE_W-1:0] WR_MODE_RESP_V = 3'h4;

	typedef struct packed {
		logic valid;
		logic sat;
		logic [MEAS_W-1:0] value;
	} meas_t;

	typedef struct packed {
		logic push;
		logic pop;
		logic empty;
		logic [MEAS_W-1:0] depth;
	} queue_mon_t;

	typedef struct packed {
		logic addr_valid;
		logic addr_ready;
		logic data_valid;
		logic data_ready;
		logic data_last;
		logic resp_valid;
		logic resp_ready;
	} chan_mon_t;

endpackage

// file: test/cache_statistics_unit_tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
begin \
	n_compared++; \
	if ((got) !== (exp)) \
	begin \
		n_mismatch++; \
		$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
	end \
end

module testbench;
	logic ref_clk_i;
	logic rst_n_i;
	logic reg_wr_i;
	logic reg_rd_i;
	logic [cache_stats_pkg::ADDR_W-1:0] reg_addr_i;
	logic [cache_stats_pkg::DATA_W-1:0] reg_wdata_i;
	logic [cache_stats_pkg::DATA_W-1:0] reg_rdata_o;
	logic reg_rvalid_o;
	cache_stats_pkg::queue_mon_t q_mon[3];
	cache_stats_pkg::meas_t m_mon[3];
	cache_stats_pkg::chan_mon_t mem_rd;
	cache_stats_pkg::chan_mon_t mem_wr;
	int n_mismatch;
	int n_compared;

	// One read transaction: valid 2 cycles, handshake, single last beat
	localparam logic [48:0] RD_SEQ =
		{7'h40, 7'h40, 7'h60, 7'h00, 7'h00, 7'h1C, 7'h00};
	// One write: address handshake, single beat, then the response
	localparam logic [48:0] WR_SEQ =
		{7'h40, 7'h60, 7'h1C, 7'h00, 7'h03, 7'h00, 7'h00};
	// Two beats, last on the second, so first and last data differ
	localparam logic [48:0] MB_SEQ =
		{7'h40, 7'h60, 7'h18, 7'h1C, 7'h00, 7'h03, 7'h00};
	// A second address handshake while the first is still measured
	localparam logic [48:0] FULL_SEQ =
		{7'h60, 7'h60, 7'h1C, 7'h00, 7'h00, 7'h00, 7'h00};

	cache_statistics_unit i_dut
	(
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i),
		.reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o),
		.reg_rvalid_o(reg_rvalid_o),
		.wr_addr_q_i(q_mon[0]),
		.wr_data_q_i(q_mon[1]),
		.rd_addr_q_i(q_mon[2]),
		.search_depth_i(m_mon[0]),
		.search_stall_i(m_mon[1]),
		.conflict_stall_i(m_mon[2]),
		.mem_rd_i(mem_rd),
		.mem_wr_i(mem_wr)
	);

	initial
	begin
		ref_clk_i = 1'h0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end

	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	function automatic logic [cache_stats_pkg::ADDR_W-1:0] ad(input logic u,
		input logic [3:0] r, input logic [1:0] w, input logic h);
		return {u, r, w, h, 2'h0};
	endfunction

	// Trailing idle cycles cover the one-cycle registered clear delay
	task automatic wr32(input logic [9:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		reg_wr_i <= 1'h1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'h0;
		repeat (3) @(posedge ref_clk_i);
	endtask

	task automatic rd32(input logic [9:0] a, output logic [31:0] d);
		@(posedge ref_clk_i);
		reg_rd_i <= 1'h1;
		reg_addr_i <= a;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'h0;
		#1;
		`CHK(reg_rvalid_o, 1'h1)
		d = reg_rdata_o;
	endtask

	task automatic chk_w(input logic u, input logic [3:0] r,
		input logic [1:0] w, input logic [63:0] e);
		logic [31:0] lo;
		logic [31:0] hi;
		rd32(ad(u, r, w, 1'h0), lo);
		rd32(ad(u, r, w, 1'h1), hi);
		`CHK({hi, lo}, e)
	endtask

	task automatic meas(input int k, input logic [15:0] v, input logic s);
		@(posedge ref_clk_i);
		m_mon[k] <= {1'h1, s, v};
		@(posedge ref_clk_i);
		m_mon[k] <= '0;
	endtask

	task automatic chan(input logic w, input logic [48:0] s);
		for (int i = 6; i >= 0; i--)
		begin
			@(posedge ref_clk_i);
			if (w)
				mem_wr <= s[7*i +: 7];
			else
				mem_rd <= s[7*i +: 7];
		end
		@(posedge ref_clk_i);
		mem_wr <= '0;
		mem_rd <= '0;
		repeat (2) @(posedge ref_clk_i);
	endtask

	task automatic done(input string n);
		$display("test %s finished", n);
	endtask

	task automatic t_reset_values;
		chk_w(1'h0, 4'h8, 2'h0, 64'h0);
		chk_w(1'h0, 4'h9, 2'h0, 64'h4);
		chk_w(1'h1, 4'h1, 2'h0, 64'h1);
		chk_w(1'h1, 4'h0, 2'h0, 64'h0);
		chk_w(1'h0, 4'hA, 2'h0, 64'h0);
		done("reset_values");
	endtask

	// Same pattern on each queue; only that queue's record may move
	task automatic t_queues;
		for (int qi = 0; qi < 3; qi++)
		begin
			@(posedge ref_clk_i);
			q_mon[qi] <= {3'h1, 16'h0000};
			repeat (5) @(posedge ref_clk_i);
			q_mon[qi] <= {3'h4, 16'h0003};
			@(posedge ref_clk_i);
			q_mon[qi] <= {3'h4, 16'h0007};
			@(posedge ref_clk_i);
			q_mon[qi] <= {3'h2, 16'h0002};
			@(posedge ref_clk_i);
			q_mon[qi] <= '0;
			chk_w(1'h0, 4'(qi), 2'h0, 64'h5);
			chk_w(1'h0, 4'(qi), 2'h1, 64'h3);
			chk_w(1'h0, 4'(qi), 2'h2, 64'h0000_0007_0000_0000);
			chk_w(1'h0, 4'(qi), 2'h3, 64'hC);
		end
		done("queues");
	endtask

	task automatic t_events;
		meas(0, 16'h0003, 1'h0);
		meas(0, 16'h0005, 1'h0);
		chk_w(1'h0, 4'h3, 2'h0, 64'h2);
		chk_w(1'h0, 4'h3, 2'h1, 64'h0003_0005_0000_0000);
		chk_w(1'h0, 4'h3, 2'h2, 64'h8);
		chk_w(1'h0, 4'h3, 2'h3, 64'h22);
		meas(2, 16'hFFFF, 1'h1);
		chk_w(1'h0, 4'h5, 2'h0, 64'h1);
		chk_w(1'h0, 4'h5, 2'h1, 64'hFFFF_FFFF_0000_0001);
		done("events");
	endtask

	task automatic t_enable;
		wr32(ad(1'h1, 4'h1, 2'h0, 1'h0), 32'h0);
		chk_w(1'h1, 4'h1, 2'h0, 64'h0);
		meas(1, 16'h0004, 1'h0);
		chk_w(1'h0, 4'h4, 2'h0, 64'h0);
		chk_w(1'h0, 4'h3, 2'h0, 64'h2);
		wr32(ad(1'h1, 4'h1, 2'h0, 1'h0), 32'h1);
		meas(1, 16'h0004, 1'h0);
		chk_w(1'h0, 4'h4, 2'h0, 64'h1);
		chk_w(1'h0, 4'h4, 2'h2, 64'h4);
		done("enable");
	endtask

	task automatic t_latency;
		logic [2:0] rm[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h3};
		logic [48:0] rs[5] = '{RD_SEQ, RD_SEQ, MB_SEQ, MB_SEQ,
			FULL_SEQ};
		int rl[5] = '{5, 3, 3, 2, 2};
		logic [2:0] modes[6] = '{3'h4, 3'h5, 3'h0, 3'h1, 3'h2, 3'h3};
		logic [48:0] ws[6] = '{WR_SEQ, WR_SEQ, WR_SEQ, WR_SEQ,
			MB_SEQ, MB_SEQ};
		int lat[6] = '{4, 3, 2, 1, 3, 2};
		int sum = 0;
		for (int i = 0; i < 5; i++)
		begin
			wr32(ad(1'h0, 4'h8, 2'h0, 1'h0), {29'h0, rm[i]});
			chk_w(1'h0, 4'h8, 2'h0, 64'(rm[i]));
			chan(1'h0, rs[i]);
			sum += rl[i];
			chk_w(1'h0, 4'h6, 2'h2, 64'(sum));
		end
		chk_w(1'h0, 4'h6, 2'h0, 64'h5);
		chk_w(1'h0, 4'h6, 2'h1, 64'h0002_0005_0000_0002);
		sum = 0;
		for (int i = 0; i < 6; i++)
		begin
			wr32(ad(1'h0, 4'h9, 2'h0, 1'h0), {29'h0, modes[i]});
			chan(1'h1, ws[i]);
			sum += lat[i];
			chk_w(1'h0, 4'h7, 2'h2, 64'(sum));
		end
		done("latency");
	endtask

	task automatic t_clear;
		wr32(ad(1'h1, 4'h0, 2'h0, 1'h0), 32'h5);
		chk_w(1'h0, 4'h3, 2'h0, 64'h0);
		chk_w(1'h0, 4'h3, 2'h1, 64'h0);
		chk_w(1'h0, 4'h3, 2'h3, 64'h0);
		chk_w(1'h0, 4'h0, 2'h2, 64'h0);
		chk_w(1'h0, 4'h5, 2'h1, 64'h0);
		chk_w(1'h0, 4'h6, 2'h2, 64'h0);
		chk_w(1'h0, 4'h6, 2'h1, 64'h0);
		chk_w(1'h0, 4'h8, 2'h0, 64'h3);
		chk_w(1'h1, 4'h0, 2'h0, 64'h0);
		meas(0, 16'h0009, 1'h0);
		chk_w(1'h0, 4'h3, 2'h1, 64'h0009_0009_0000_0000);
		done("clear");
	endtask

	initial
	begin
		n_mismatch = 0;
		n_compared = 0;
		rst_n_i = 1'h0;
		reg_wr_i = 1'h0;
		reg_rd_i = 1'h0;
		reg_addr_i = '0;
		reg_wdata_i = '0;
		q_mon = '{default: '0};
		m_mon = '{default: '0};
		mem_rd = '0;
		mem_wr = '0;
		repeat (6) @(posedge ref_clk_i);
		rst_n_i <= 1'h1;
		// Requests are only taken from the third edge after release
		repeat (4) @(posedge ref_clk_i);
		t_reset_values();
		t_queues();
		t_events();
		t_enable();
		t_latency();
		t_clear();
		end_of_test();
	end

	// Whole run needs well under 2000 cycles
	initial
	begin
		repeat (20000) @(posedge ref_clk_i);
		n_mismatch++;
		$display("watchdog expired");
		end_of_test();
	end
endmodule
